// ==== cpt_top.sv ====
// compact timer with AHB-Lite register slave
`timescale 1ns/1ns
`include "cpt_defs.svh"
module cpt_top
    import cpt_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // clock sources
    input wire logic ext_count_clock_in,
    input wire logic sub_clock_in,
    // timer outputs
    output logic timer_out_pin,
    output logic irq_cmp_a,
    output logic irq_cmp_p
);
    // ---------------------------------------------
    // bus phases
    // ---------------------------------------------
    function automatic logic at(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    logic take;
    logic rd_go;
    logic [7:0] a_adr;
    logic dp_wr_ff;
    logic nxt_dp_wr;
    logic [7:0] dp_adr_ff;
    logic [7:0] nxt_dp_adr;

    // zero wait state slave, always OKAY
    assign take = hsel && htrans[1] && hready;
    assign rd_go = take && !hwrite;
    assign a_adr = haddr[7:0];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_comb begin
        nxt_dp_wr = take && hwrite;
        nxt_dp_adr = take ? a_adr : dp_adr_ff;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_ff <= 1'b0;
            dp_adr_ff <= `CPT_RST_BYTE;
        end else begin
            dp_wr_ff <= nxt_dp_wr;
            dp_adr_ff <= nxt_dp_adr;
        end
    end

    // ---------------------------------------------
    // software registers
    // ---------------------------------------------
    logic pause_ff, nxt_pause;
    logic [2:0] cks_ff, nxt_cks;
    logic on_ff, nxt_on;
    logic [7:0] ctrl1_ff, nxt_ctrl1;
    logic [15:0] cmpa_ff, nxt_cmpa;
    logic [7:0] period_ff, nxt_period;
    logic [7:0] hold_ff, nxt_hold;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [15:0] cnt_ff;
    logic [7:0] rd_byte;
    logic [7:0] wb;
    logic on_rise;

    assign wb = hwdata[7:0];
    assign on_rise = nxt_on & ~on_ff;

    // read mux; low bytes come back through the shared buffer
    always_comb begin
        case (a_adr)
            `CPT_OFF_CTRL0: rd_byte = {pause_ff, cks_ff, on_ff, 3'h0};
            `CPT_OFF_CTRL1: rd_byte = ctrl1_ff;
            `CPT_OFF_CNT_LO: rd_byte = hold_ff; // RULE15
            `CPT_OFF_CNT_HI: rd_byte = cnt_ff[15:8]; // RULE14
            `CPT_OFF_CMPA_LO: rd_byte = hold_ff; // RULE15
            `CPT_OFF_CMPA_HI: rd_byte = cmpa_ff[15:8]; // RULE14
            `CPT_OFF_PERIOD: rd_byte = period_ff;
            default: rd_byte = 8'h00;
        endcase
    end

    // writes land in the data phase, reads act in the address phase
    always_comb begin
        nxt_pause = pause_ff;
        nxt_cks = cks_ff;
        nxt_on = on_ff;
        nxt_ctrl1 = ctrl1_ff;
        nxt_cmpa = cmpa_ff;
        nxt_period = period_ff;
        nxt_hold = hold_ff;
        nxt_rdata = rdata_ff;
        if (dp_wr_ff) begin
            if (at(dp_adr_ff, `CPT_OFF_CTRL0)) begin
                nxt_pause = wb[`CPT_C0_PAUSE];
                nxt_cks = wb[`CPT_C0_CKS_HI:`CPT_C0_CKS_LO];
                nxt_on = wb[`CPT_C0_ON];
            end
            if (at(dp_adr_ff, `CPT_OFF_CTRL1)) begin
                nxt_ctrl1 = wb;
            end
            if (at(dp_adr_ff, `CPT_OFF_CMPA_LO)) begin
                nxt_hold = wb; // RULE12
            end
            if (at(dp_adr_ff, `CPT_OFF_CMPA_HI)) begin
                nxt_cmpa = {wb, hold_ff}; // RULE13 RULE16
            end
            if (at(dp_adr_ff, `CPT_OFF_PERIOD)) begin
                nxt_period = wb;
            end
        end
        // a high read is later in program order, so its capture wins
        if (rd_go && at(a_adr, `CPT_OFF_CNT_HI)) begin
            nxt_hold = cnt_ff[7:0]; // RULE14 RULE16
        end
        if (rd_go && at(a_adr, `CPT_OFF_CMPA_HI)) begin
            nxt_hold = cmpa_ff[7:0]; // RULE14
        end
        if (rd_go) begin
            nxt_rdata = {24'h000000, rd_byte};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pause_ff <= 1'b0;
            cks_ff <= 3'h0;
            on_ff <= 1'b0;
            ctrl1_ff <= `CPT_RST_BYTE;
            cmpa_ff <= `CPT_RST_WORD;
            period_ff <= `CPT_RST_BYTE;
            hold_ff <= `CPT_RST_BYTE;
            rdata_ff <= 32'h00000000;
        end else begin
            pause_ff <= nxt_pause;
            cks_ff <= nxt_cks;
            on_ff <= nxt_on;
            ctrl1_ff <= nxt_ctrl1;
            cmpa_ff <= nxt_cmpa;
            period_ff <= nxt_period;
            hold_ff <= nxt_hold;
            rdata_ff <= nxt_rdata;
        end
    end
    assign hrdata = rdata_ff;

    // ---------------------------------------------
    // count strobe
    // ---------------------------------------------
    logic tick;

    cpt_tick u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .count_clock_select(cks_ff),
        .ext_count_clock_in(ext_count_clock_in),
        .sub_clock_in(sub_clock_in),
        .tick(tick)
    );

    // ---------------------------------------------
    // counter and comparators
    // ---------------------------------------------
    cpt_mode_t mode;
    cpt_io_t io;
    logic oc, pol, dpx, cclr;
    logic run, a_hit, p_hit, clr;
    logic [7:0] p_top;
    logic [15:0] nxt_cnt;

    assign mode = cpt_mode_t'(ctrl1_ff[`CPT_C1_MODE_HI:`CPT_C1_MODE_LO]);
    assign io = cpt_io_t'(ctrl1_ff[`CPT_C1_IO_HI:`CPT_C1_IO_LO]);
    assign oc = ctrl1_ff[`CPT_C1_OC];
    assign pol = ctrl1_ff[`CPT_C1_POL];
    assign dpx = ctrl1_ff[`CPT_C1_DPX];
    assign cclr = ctrl1_ff[`CPT_C1_CCLR];
    assign run = tick && on_ff && !pause_ff; // RULE18
    // period zero wraps to overflow, which keeps one match path
    assign p_top = cnt_ff[15:8] + 8'h01;
    assign p_hit = run && (cnt_ff[7:0] == 8'hFF) && (p_top == period_ff); // RULE2
    assign a_hit = run && (cnt_ff == cmpa_ff); // RULE3

    // pwm clears on its period comparator, others on the clear select
    always_comb begin
        if (mode == CPT_MODE_PWM) begin
            clr = dpx ? a_hit : p_hit;
        end else begin
            clr = cclr ? a_hit : p_hit; // RULE21 RULE7
        end
        nxt_cnt = cnt_ff;
        if (on_rise) begin
            nxt_cnt = `CPT_RST_WORD; // RULE4
        end else if (clr) begin
            nxt_cnt = `CPT_RST_WORD; // RULE5
        end else if (run) begin
            nxt_cnt = cnt_ff + 16'h0001; // RULE1 RULE18
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= `CPT_RST_WORD;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // ---------------------------------------------
    // output pin and match strobes
    // ---------------------------------------------
    logic lvl_ff, nxt_lvl;
    logic out_ff, nxt_out;
    logic irqa_ff, irqp_ff;
    logic duty;

    // edge aligned pwm: active while counter is below the duty value
    assign duty = dpx ? (cnt_ff[15:8] < period_ff) : (cnt_ff < cmpa_ff);

    always_comb begin
        nxt_lvl = lvl_ff;
        if (on_rise) begin
            nxt_lvl = oc; // RULE20
        end else if (mode == CPT_MODE_CMP && a_hit) begin
            unique case (io) // RULE8 RULE7
                CPT_IO_KEEP: nxt_lvl = lvl_ff;
                CPT_IO_LOW: nxt_lvl = 1'b0;
                CPT_IO_HIGH: nxt_lvl = 1'b1;
                CPT_IO_TOG: nxt_lvl = ~lvl_ff;
            endcase
        end
        unique case (mode) // RULE17 RULE22
            CPT_MODE_CMP: nxt_out = nxt_lvl ^ pol;
            CPT_MODE_PWM: begin
                unique case (io) // RULE9
                    CPT_IO_LOW: nxt_out = oc ^ pol;
                    CPT_IO_HIGH: nxt_out = (duty ? oc : ~oc) ^ pol;
                    default: nxt_out = ~oc ^ pol;
                endcase
            end
            // timer mode and the undefined code hold the pin low
            default: nxt_out = 1'b0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lvl_ff <= 1'b0;
            out_ff <= 1'b0;
            irqa_ff <= 1'b0;
            irqp_ff <= 1'b0;
        end else begin
            lvl_ff <= nxt_lvl;
            out_ff <= nxt_out;
            irqa_ff <= a_hit; // RULE6
            irqp_ff <= p_hit; // RULE6
        end
    end
    assign timer_out_pin = out_ff;
    assign irq_cmp_a = irqa_ff;
    assign irq_cmp_p = irqp_ff;

    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_hi_read;
        rd_go && a_adr == `CPT_OFF_CNT_HI;
    endsequence
    sequence s_lo_write;
        dp_wr_ff && dp_adr_ff == `CPT_OFF_CMPA_LO;
    endsequence

    on_clear_a: assert property ($rose(on_ff) |-> cnt_ff == 16'h0000) // RULE4
        else $error("counter not cleared when timer switched on");
    count_step_a: assert property (run && !clr && !on_rise // RULE18
        |=> cnt_ff == 16'($past(cnt_ff) + 16'h0001))
        else $error("counter did not step by one");
    count_hold_a: assert property (!run && !on_rise |=> $stable(cnt_ff)) // RULE4
        else $error("counter moved without a count strobe");
    a_clear_a: assert property (a_hit && cclr && mode != CPT_MODE_PWM // RULE21
        && !on_rise |=> cnt_ff == 16'h0000)
        else $error("compare A match did not clear counter");
    irq_pair_a: assert property (p_hit |=> irq_cmp_p ##1 !irq_cmp_p) // RULE6
        else $error("period match strobe wrong");
    buf_only_a: assert property (s_lo_write |=> $stable(cmpa_ff)) // RULE12
        else $error("low byte write reached compare register");
    hi_write_a: assert property (dp_wr_ff // RULE13
        && dp_adr_ff == `CPT_OFF_CMPA_HI
        |=> cmpa_ff == {$past(hwdata[7:0]), $past(hold_ff)})
        else $error("high byte write did not merge buffer");
    hi_read_a: assert property (s_hi_read // RULE14
        |=> hold_ff == $past(cnt_ff[7:0]) && hrdata[7:0] == $past(cnt_ff[15:8]))
        else $error("counter high read wrong");
    lo_read_a: assert property (rd_go && a_adr == `CPT_OFF_CNT_LO // RULE15
        |=> hrdata == {24'h000000, $past(hold_ff)})
        else $error("low read did not return buffer");
    cmp_high_a: assert property (mode == CPT_MODE_CMP // RULE8
        && io == CPT_IO_HIGH
        && a_hit && !on_rise |=> timer_out_pin == ~$past(pol))
        else $error("compare output not driven high");
    tmr_pin_a: assert property (mode == CPT_MODE_TMR // RULE17
        |=> !timer_out_pin)
        else $error("timer mode pin not low");
endmodule

// ==== cpt_defs.svh ====
// register map, field layout, reset values and divider masks of the timer
// What this block does
// RULE1 - sixteen-bit counter counts only upward from a software-chosen clock
// RULE2 - eight-bit period value compared only with counter upper byte
// RULE3 - sixteen-bit compare-A value compared with every counter bit
// RULE4 - software cannot load counter; besides the match clears of RULE5, only on-bit rising clears it
// RULE5 - counter clears on overflow or selected match, raising an interrupt
// RULE6 - separate interrupt for comparator A and for comparator P
// RULE7 - compare match can change output pin and clear counter
// RULE8 - compare output mode drives pin high, low or toggles
// RULE9 - pwm waveform leaves on the same single output pin
// RULE10 - external clock pin counts events on rising or falling edge
// RULE11 - three-bit select picks system, high, sub or external clock
// RULE12 - low byte write to compare register only loads holding buffer
// RULE13 - high byte write loads high byte and moves buffer to low
// RULE14 - high byte read returns byte and captures low byte into buffer
// RULE15 - low byte read returns holding buffer, not live low byte
// RULE16 - software writes low then high, reads high then low
// RULE17 - three modes: compare output, timer counter, pwm; no single pulse
// RULE18 - counter steps by one per active edge while on and running
// RULE19 - select codes: sys/4, sys, high/16, high/64, sub, sub, ext edges
// RULE20 - on-bit rising returns output pin to configured initial level
// RULE21 - clear-select one clears on A match, zero on P or overflow
// RULE22 - mode field: 00 compare, 10 pwm, 11 timer, 01 undefined
`ifndef CPT_DEFS_SVH
`define CPT_DEFS_SVH

// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define CPT_OFF_CTRL0 8'h00
`define CPT_OFF_CTRL1 8'h04
`define CPT_OFF_CNT_LO 8'h08
`define CPT_OFF_CNT_HI 8'h0C
`define CPT_OFF_CMPA_LO 8'h10
`define CPT_OFF_CMPA_HI 8'h14
`define CPT_OFF_PERIOD 8'h18

// ---------------------------------------------
// field positions
// ---------------------------------------------
`define CPT_C0_PAUSE 7
`define CPT_C0_CKS_HI 6
`define CPT_C0_CKS_LO 4
`define CPT_C0_ON 3
`define CPT_C1_MODE_HI 7
`define CPT_C1_MODE_LO 6
`define CPT_C1_IO_HI 5
`define CPT_C1_IO_LO 4
`define CPT_C1_OC 3
`define CPT_C1_POL 2
`define CPT_C1_DPX 1
`define CPT_C1_CCLR 0

// ---------------------------------------------
// reset values and divider masks
// ---------------------------------------------
`define CPT_RST_BYTE 8'h00
`define CPT_RST_WORD 16'h0000
`define CPT_DIV4_MASK 6'h03
`define CPT_DIV16_MASK 6'h0F
`define CPT_DIV64_MASK 6'h3F

`endif

// ==== cpt_pkg.sv ====
// types shared by the compact timer modules
package cpt_pkg;
    typedef enum logic [1:0] {
        CPT_MODE_CMP = 2'h0,
        CPT_MODE_UNDEF = 2'h1,
        CPT_MODE_PWM = 2'h2,
        CPT_MODE_TMR = 2'h3
    } cpt_mode_t;
    typedef enum logic [2:0] {
        CPT_CKS_SYS4 = 3'h0,
        CPT_CKS_SYS = 3'h1,
        CPT_CKS_HI16 = 3'h2,
        CPT_CKS_HI64 = 3'h3,
        CPT_CKS_SUB0 = 3'h4,
        CPT_CKS_SUB1 = 3'h5,
        CPT_CKS_EXTR = 3'h6,
        CPT_CKS_EXTF = 3'h7
    } cpt_cks_t;
    typedef enum logic [1:0] {
        CPT_IO_KEEP = 2'h0,
        CPT_IO_LOW = 2'h1,
        CPT_IO_HIGH = 2'h2,
        CPT_IO_TOG = 2'h3
    } cpt_io_t;
endpackage

// ==== cpt_tick.sv ====
// count strobe generator: prescaler, pin synchronisers, edge pick
`timescale 1ns/1ns
`include "cpt_defs.svh"
module cpt_tick
    import cpt_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // clock choice
    input wire logic [2:0] count_clock_select,
    // outside clock sources
    input wire logic ext_count_clock_in,
    input wire logic sub_clock_in,
    // one-cycle count strobe
    output logic tick
);
    // ---------------------------------------------
    // synchronisers and edge detect
    // ---------------------------------------------
    logic [1:0] src;
    logic [1:0] rise;
    logic [1:0] fall;
    assign src = {sub_clock_in, ext_count_clock_in};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            // s1 feeds only s2; edges come from s2 against s3
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                    s3_ff <= 1'b0;
                end else begin
                    s1_ff <= src[gi];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                end
            end
            assign rise[gi] = s2_ff & ~s3_ff;
            assign fall[gi] = ~s2_ff & s3_ff;
        end
    endgenerate

    // ---------------------------------------------
    // prescaler, high clock taken as hclk
    // ---------------------------------------------
    logic [5:0] div_ff;
    logic [5:0] nxt_div;

    always_comb begin
        nxt_div = div_ff + 6'h01;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_ff <= 6'h00;
        end else begin
            div_ff <= nxt_div;
        end
    end

    // source pick; pin edges lag the pin by two hclk
    always_comb begin
        unique case (cpt_cks_t'(count_clock_select)) // RULE11 RULE19
            CPT_CKS_SYS4: tick = (div_ff & `CPT_DIV4_MASK) == `CPT_DIV4_MASK;
            CPT_CKS_SYS: tick = 1'b1;
            CPT_CKS_HI16: tick = (div_ff & `CPT_DIV16_MASK) == `CPT_DIV16_MASK;
            CPT_CKS_HI64: tick = div_ff == `CPT_DIV64_MASK;
            CPT_CKS_SUB0: tick = rise[1];
            CPT_CKS_SUB1: tick = rise[1];
            CPT_CKS_EXTR: tick = rise[0]; // RULE10
            CPT_CKS_EXTF: tick = fall[0]; // RULE10
        endcase
    end
endmodule

// ==== test_compact_timer_module.sv ====
// self-checking testbench for the compact timer with its register slave
`timescale 1ns/1ns
`include "cpt_defs.svh"
module test_compact_timer_module import cpt_pkg::*;;
    // ---------------------------------------------
    // stimulus and observed signals
    // ---------------------------------------------
    logic hclk, hresetn, hsel, hwrite, ext_count_clock_in, sub_clock_in;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, timer_out_pin, irq_cmp_a, irq_cmp_p;
    wire logic hready;
    int cyc, mismatches, samples_checked, na;
    logic [3:0] sub_div;

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    cpt_top i_cpt_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata),
        .ext_count_clock_in(ext_count_clock_in),
        .sub_clock_in(sub_clock_in), .timer_out_pin(timer_out_pin),
        .irq_cmp_a(irq_cmp_a), .irq_cmp_p(irq_cmp_p));

    // ---------------------------------------------
    // clock, sub clock, cycle and interrupt counters
    // ---------------------------------------------
    always #50 hclk = ~hclk;

    // sub clock of 14 hclk periods, so its tick spacing is exact
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (irq_cmp_a === 1'b1) na <= na + 1;
        if (sub_div == 4'h6) begin
            sub_div <= 4'h0;
            sub_clock_in <= ~sub_clock_in;
        end else sub_div <= sub_div + 4'h1;
    end

    // hang guard: the full run takes well under this
    always @(posedge hclk) begin
        if (cyc == 90000) begin
            mismatches++;
            $display("mismatch at %0t: timeout", $time);
            give_verdict();
        end
    end

    // ---------------------------------------------
    // compare, bus and pin tasks
    // ---------------------------------------------
    task check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    task check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: level %b expected %b", $time, got, exp);
        end
    endtask

    // address phase held until ready, then data phase until ready
    task bus_xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                  output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task bus_write(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus_xfer(1'b1, a, d, r);
    endtask

    task read_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus_xfer(1'b0, a, 8'h00, r);
        check_val(r, exp);
    endtask

    // high byte first, so the low byte comes from the captured buffer
    task read_cnt(output logic [31:0] v);
        logic [31:0] h, l;
        bus_xfer(1'b0, `CPT_OFF_CNT_HI, 8'h00, h);
        bus_xfer(1'b0, `CPT_OFF_CNT_LO, 8'h00, l);
        v = {16'h0000, h[7:0], l[7:0]};
    endtask

    task set_cmpa(input logic [15:0] v);
        bus_write(`CPT_OFF_CMPA_LO, v[7:0]);
        bus_write(`CPT_OFF_CMPA_HI, v[15:8]);
    endtask

    // each pulse is wide enough to pass the pin synchroniser
    task pulse_ext(input int n);
        repeat (n) begin
            ext_count_clock_in <= 1'b1;
            repeat (4) @(posedge hclk);
            ext_count_clock_in <= 1'b0;
            repeat (4) @(posedge hclk);
        end
    endtask

    task wait_irq(input logic p, output int t);
        int k;
        for (k = 0; k < 20000; k++) begin
            @(posedge hclk);
            if ((p ? irq_cmp_p : irq_cmp_a) === 1'b1) break;
        end
        t = cyc;
    endtask

    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task test_reset();
        check_bit(timer_out_pin, 1'b0);
        check_bit(irq_cmp_a | irq_cmp_p | hresp, 1'b0);
        read_chk(`CPT_OFF_CTRL0, 32'h00000000);
        read_chk(`CPT_OFF_CTRL1, 32'h00000000);
        read_chk(`CPT_OFF_CNT_HI, 32'h00000000);
        read_chk(`CPT_OFF_CMPA_HI, 32'h00000000);
        read_chk(`CPT_OFF_PERIOD, 32'h00000000);
    endtask

    task test_regs();
        bus_write(`CPT_OFF_CTRL1, 8'h5A);
        read_chk(`CPT_OFF_CTRL1, 32'h0000005A);
        // the undefined mode code keeps the pin low
        check_bit(timer_out_pin, 1'b0);
        bus_write(`CPT_OFF_CTRL0, 8'hF7);
        read_chk(`CPT_OFF_CTRL0, 32'h000000F0);
        bus_write(`CPT_OFF_CTRL0, 8'h00);
        bus_write(`CPT_OFF_PERIOD, 8'hA5);
        read_chk(`CPT_OFF_PERIOD, 32'h000000A5);
        bus_write(8'h1C, 8'hFF);
        read_chk(8'h1C, 32'h00000000);
        bus_write(`CPT_OFF_CNT_HI, 8'h77);
        read_chk(`CPT_OFF_CNT_HI, 32'h00000000);
    endtask

    task test_buffer();
        bus_write(`CPT_OFF_CMPA_LO, 8'h34);
        read_chk(`CPT_OFF_CMPA_HI, 32'h00000000);
        read_chk(`CPT_OFF_CMPA_LO, 32'h00000000);
        set_cmpa(16'h1234);
        read_chk(`CPT_OFF_CMPA_HI, 32'h00000012);
        read_chk(`CPT_OFF_CMPA_LO, 32'h00000034);
        read_chk(`CPT_OFF_CNT_LO, 32'h00000034);
    endtask

    task test_ext();
        logic [31:0] v;
        bus_write(`CPT_OFF_PERIOD, 8'h00);
        bus_write(`CPT_OFF_CTRL1, 8'hC0);
        bus_write(`CPT_OFF_CTRL0, 8'h68);
        pulse_ext(5);
        read_cnt(v);
        check_val(v, 32'h00000005);
        // falling edge select: one count per pulse again
        bus_write(`CPT_OFF_CTRL0, 8'h78);
        pulse_ext(3);
        read_cnt(v);
        check_val(v, 32'h00000008);
        bus_write(`CPT_OFF_CTRL0, 8'h70);
        bus_write(`CPT_OFF_CTRL0, 8'h78);
        read_cnt(v);
        check_val(v, 32'h00000000);
    endtask

    // io codes keep, low, high, toggle; match on the fourth edge
    task test_cmp_out();
        int i, n0;
        logic [31:0] v;
        set_cmpa(16'h0003);
        for (i = 0; i < 4; i++) begin
            n0 = na;
            bus_write(`CPT_OFF_CTRL0, 8'h60);
            bus_write(`CPT_OFF_CTRL1, {2'h0, i[1:0], i == 1, 3'h1});
            bus_write(`CPT_OFF_CTRL0, 8'h68);
            @(posedge hclk);
            check_bit(timer_out_pin, i == 1);
            pulse_ext(4);
            check_bit(timer_out_pin, i >= 2);
            check_val(na - n0, 1);
            read_cnt(v);
            check_val(v, 32'h00000000);
        end
        pulse_ext(4);
        check_bit(timer_out_pin, 1'b0);
    endtask

    // period 1 matches once per 256 ticks of the chosen clock
    task test_clock_sel();
        int c, t0, t1;
        int sp[6] = '{1024, 256, 4096, 16384, 3584, 3584};
        bus_write(`CPT_OFF_CTRL1, 8'hC0);
        bus_write(`CPT_OFF_PERIOD, 8'h01);
        set_cmpa(16'hFFFF);
        for (c = 0; c < 6; c++) begin
            bus_write(`CPT_OFF_CTRL0, {1'b0, c[2:0], 4'h8});
            wait_irq(1'b1, t0);
            wait_irq(1'b1, t1);
            check_val(t1 - t0, sp[c]);
        end
    endtask

    task test_clear_a();
        int t0, t1, n0;
        logic [31:0] v0, v1;
        bus_write(`CPT_OFF_CTRL1, 8'hC1);
        set_cmpa(16'h0009);
        // restart, or a count already past the match wraps all the way
        bus_write(`CPT_OFF_CTRL0, 8'h10);
        bus_write(`CPT_OFF_CTRL0, 8'h18);
        wait_irq(1'b0, t0);
        wait_irq(1'b0, t1);
        check_val(t1 - t0, 10);
        bus_write(`CPT_OFF_CTRL0, 8'h98);
        // a match on the pausing edge still pulses; let it be counted
        repeat (2) @(posedge hclk);
        n0 = na;
        read_cnt(v0);
        repeat (20) @(posedge hclk);
        read_cnt(v1);
        check_val(v1, v0);
        check_val(na - n0, 0);
    endtask

    // duty 0x40 of a 256-cycle period: 128 high cycles in any 512
    task test_pwm();
        int n;
        n = 0;
        bus_write(`CPT_OFF_CTRL0, 8'h10);
        bus_write(`CPT_OFF_CTRL1, 8'hA8);
        set_cmpa(16'h0040);
        bus_write(`CPT_OFF_CTRL0, 8'h18);
        repeat (300) @(posedge hclk);
        repeat (512) begin
            @(posedge hclk);
            if (timer_out_pin === 1'b1) n++;
        end
        check_val(n, 128);
        // swapped roles, inverted: period 1024 from A, duty 256 from P
        bus_write(`CPT_OFF_CTRL0, 8'h10);
        bus_write(`CPT_OFF_CTRL1, 8'hAE);
        set_cmpa(16'h03FF);
        bus_write(`CPT_OFF_CTRL0, 8'h18);
        repeat (300) @(posedge hclk);
        n = 0;
        repeat (1024) begin
            @(posedge hclk);
            if (timer_out_pin === 1'b1) n++;
        end
        check_val(n, 768);
        bus_write(`CPT_OFF_CTRL0, 8'h10);
        bus_write(`CPT_OFF_CTRL1, 8'h98);
        bus_write(`CPT_OFF_CTRL0, 8'h18);
        repeat (4) @(posedge hclk);
        check_bit(timer_out_pin, 1'b1);
        bus_write(`CPT_OFF_CTRL1, 8'hC8);
        repeat (4) @(posedge hclk);
        check_bit(timer_out_pin, 1'b0);
    endtask

    // ---------------------------------------------
    // verdict and main sequence
    // ---------------------------------------------
    task give_verdict();
        $display("checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        ext_count_clock_in = 1'b0;
        sub_clock_in = 1'b0;
        sub_div = 4'h0;
        cyc = 0;
        na = 0;
        mismatches = 0;
        samples_checked = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_reset();
        test_regs();
        test_buffer();
        test_ext();
        test_cmp_out();
        test_clock_sel();
        test_clear_a();
        test_pwm();
        give_verdict();
    end
endmodule
